//--- lsr_router.sv
// Routing decision, outstanding-request table and per-port registers of the link switch
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module lsr_router
  import lsr_pkg::*;
#(
  parameter int NPORT = 8,
  parameter int NPRI  = 2,
  parameter int TAGS  = 32
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AW-1:0]     paddr,
  input  wire logic [DW-1:0]     pwdata,
  output logic      [DW-1:0]     prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              pkt_valid,
  output logic                   pkt_ready,
  input  wire logic [PW-1:0]     pkt_port,
  input  wire lsr_kind_e         pkt_kind,
  input  wire logic [PW-1:0]     pkt_dest,
  input  wire logic              pkt_compat,
  input  wire logic              pkt_bridge,
  input  wire logic              pkt_err,
  input  wire logic              pkt_nxa,
  input  wire logic [TW-1:0]     source_tag,
  input  wire logic [SQW-1:0]    sequence_id,
  input  wire logic [UW-1:0]     unit_id_a,
  input  wire logic [BW-1:0]     pkt_bus,
  input  wire logic [DNW-1:0]    pkt_dev,
  input  wire logic [DW-1:0]     pkt_data,
  output logic                   out_valid,
  output lsr_action_e            out_action,
  output logic [PW-1:0]          out_port,
  output logic                   out_compat,
  output logic                   out_err,
  output logic                   out_nxa,
  output logic [TW-1:0]          out_source_tag,
  output logic [SQW-1:0]         out_sequence_id,
  output logic [UW-1:0]          out_unit_id,
  output logic [MAXP-1:0]        out_event_mask,
  output logic [DW-1:0]          out_data
);

  // Per-port configuration and status
  logic                  dec_q [MAXP];
  logic                  mam_q [MAXP];
  logic                  uce_q [MAXP];
  logic                  slv_q [MAXP];
  logic [PW-1:0]         dp_q  [MAXP];
  logic [DNW-1:0]        dn_q  [MAXP];
  logic [MAXP-1:0]       pm_q  [MAXP];
  logic [BW-1:0]         pb_q  [MAXP];
  logic [BW-1:0]         sb_q  [MAXP];
  logic [BW-1:0]         ub_q  [MAXP];
  logic [UW-1:0]         uid_q [MAXP];
  logic [NSTAT-1:0]      st_q  [MAXP];
  logic [NSTAT-1:0]      st_set [MAXP];

  // Outstanding-request table, indexed by the reassigned tag
  logic                  tv_q   [2**TW];
  logic [TW-1:0]         ttag_q [2**TW];
  logic [SQW-1:0]        tseq_q [2**TW];
  logic [UW-1:0]         tuid_q [2**TW];
  logic [PW-1:0]         tprt_q [2**TW];

  function automatic logic is_pri(input logic [PW-1:0] p);
    is_pri = int'(p) < NPRI;
  endfunction : is_pri

  function automatic logic mate(input logic [PW-1:0] a, input logic [PW-1:0] b);
    mate = pm_q[a][b] & pm_q[b][a];
  endfunction : mate

  function automatic logic reach(input logic [PW-1:0] a, input logic [PW-1:0] b);
    reach = (int'(b) < NPORT) && !(is_pri(a) && is_pri(b)) && ((a == b) || mate(a, b));
  endfunction : reach

  // APB decode: port in paddr[7:4], word in paddr[3:0]
  wire logic [PW-1:0] a_port  = paddr[7:4];
  wire logic [3:0]    a_word  = paddr[3:0];
  wire logic          a_ok    = (paddr[AW-1:8] == '0) && (int'(a_port) < NPORT) &&
                                ((a_word == REG_CTRL) || (a_word == REG_BUS) || (a_word == REG_STAT));
  wire logic          wr_en   = psel && penable && pwrite && a_ok;
  wire logic [DW-1:0] rd_ctrl = {pm_q[a_port], 3'h0, dn_q[a_port], dp_q[a_port],
                                 slv_q[a_port], uce_q[a_port], mam_q[a_port], dec_q[a_port]};
  wire logic [DW-1:0] rd_bus  = {3'h0, uid_q[a_port], ub_q[a_port], sb_q[a_port], pb_q[a_port]};
  wire logic [DW-1:0] rd_stat = {{(DW-NSTAT){1'b0}}, st_q[a_port]};
  wire logic [DW-1:0] rd_val  = !a_ok ? '0 :
                                (a_word == REG_CTRL) ? rd_ctrl :
                                (a_word == REG_BUS)  ? rd_bus  : rd_stat;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !a_ok;

  // Read data captured in the setup cycle, presented in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable)
      prdata <= rd_val;
  end

  // Free tag search among the first TAGS entries
  logic          free_any;
  logic [TW-1:0] free_idx;
  always_comb
  begin
    free_any = 1'b0;
    free_idx = '0;
    for (int i = TAGS - 1; i >= 0; i--)
    begin
      if (!tv_q[i])
      begin
        free_any = 1'b1;
        free_idx = TW'(i);
      end
    end
  end

  // Routing decision
  wire logic [PW-1:0] ip     = pkt_port;
  wire logic          ip_ok  = int'(ip) < NPORT;
  wire logic          ip_pri = is_pri(ip);
  wire logic          rsp_ma = pkt_err && pkt_nxa;
  wire logic          rsp_ta = pkt_err && !pkt_nxa;

  lsr_action_e     act;
  logic [PW-1:0]   eg;
  logic            compat_o;
  logic            err_o;
  logic            nxa_o;
  logic [TW-1:0]   tag_o;
  logic [SQW-1:0]  seq_o;
  logic [UW-1:0]   uid_o;
  logic [MAXP-1:0] evm;
  logic            alloc;
  logic            rel;
  logic            rng_hit;
  logic            rng_multi;
  logic [PW-1:0]   rng_port;

  always_comb
  begin
    rng_hit   = 1'b0;
    rng_multi = 1'b0;
    rng_port  = '0;
    for (int p = 0; p < NPORT; p++)
    begin
      if (!is_pri(PW'(p)) && mate(ip, PW'(p)) && (pkt_bus >= sb_q[p]) && (pkt_bus <= ub_q[p]))
      begin
        rng_multi = rng_hit;
        rng_hit   = 1'b1;
        rng_port  = PW'(p);
      end
    end
  end

  always_comb
  begin
    act      = A_DROP;
    eg       = ip;
    compat_o = pkt_compat;
    err_o    = pkt_err;
    nxa_o    = pkt_nxa;
    tag_o    = source_tag;
    seq_o    = sequence_id;
    uid_o    = unit_id_a;
    evm      = '0;
    rel      = 1'b0;
    for (int i = 0; i < MAXP; i++)
      st_set[i] = '0;
    if (ip_ok)
    begin
      unique case (pkt_kind)
        K_POSTED, K_NONPOSTED:
        begin
          if (ip_pri)
            eg = (pkt_compat || !dec_q[ip]) ? dp_q[ip] : pkt_dest;
          else
          begin
            eg       = pkt_dest;
            compat_o = (!is_pri(pkt_dest) && pkt_dest != ip) ? 1'b0 : pkt_compat;
          end
          if (reach(ip, eg))
            act = A_FORWARD;
          else if (pkt_kind == K_NONPOSTED)
            act = A_MABORT;
        end
        K_CFG0:
        begin
          if (ip_pri || pkt_dev == dn_q[ip])
            act = A_LOCAL;
          else
            act = A_MABORT;
        end
        K_CFG1:
        begin
          if (ip_pri)
          begin
            if (pkt_bus == sb_q[ip])
            begin
              eg  = PW'(pkt_dev);
              act = (int'(pkt_dev) < NPORT && !is_pri(PW'(pkt_dev)) && mate(ip, PW'(pkt_dev))) ?
                    A_LOCAL : A_MABORT;
            end
            else if (rng_hit && !rng_multi)
            begin
              eg  = rng_port;
              act = A_FORWARD;
            end
            else
              act = A_MABORT;
          end
          else if (!uce_q[ip])
            act = A_MABORT;
          else if (pkt_bus == pb_q[ip])
          begin
            eg  = PW'(pkt_dev);
            act = (int'(pkt_dev) < NPORT && !is_pri(PW'(pkt_dev)) && reach(ip, PW'(pkt_dev))) ?
                  A_LOCAL : A_MABORT;
          end
          else
          begin
            eg  = dp_q[ip];
            act = reach(ip, eg) ? A_FORWARD : A_MABORT;
          end
        end
        K_FLUSH:
        begin
          if (ip_pri)
            act = A_MABORT;
          else
          begin
            eg  = dp_q[ip];
            act = reach(ip, eg) ? A_FORWARD : A_MABORT;
          end
        end
        K_FENCE:
        begin
          if (ip_pri)
            st_set[ip][ST_EOC] = 1'b1;
          else
          begin
            eg  = dp_q[ip];
            act = reach(ip, eg) ? A_FORWARD : A_DROP;
          end
        end
        K_EVENT:
        begin
          act = A_EVENT;
          for (int p = 0; p < NPORT; p++)
            evm[p] = (PW'(p) != ip) && mate(ip, PW'(p));
        end
        K_RESP:
        begin
          if (!ip_pri && pkt_bridge)
            st_set[ip][ST_HEOC] = 1'b1;
          else if (ip_pri && (!pkt_bridge || unit_id_a != uid_q[ip]))
            st_set[ip][ST_EOC] = 1'b1;
          else if (!tv_q[source_tag])
            st_set[ip][ST_RSPE] = 1'b1;
          else
          begin
            act   = A_FORWARD;
            eg    = tprt_q[source_tag];
            tag_o = ttag_q[source_tag];
            seq_o = tseq_q[source_tag];
            uid_o = tuid_q[source_tag];
            rel   = 1'b1;
            if (eg != ip && rsp_ma && !mam_q[ip])
            begin
              st_set[ip][ip_pri ? ST_RMA : SS_RMA] = 1'b1;
              err_o = 1'b0;
              nxa_o = 1'b0;
            end
            else if (eg != ip && (rsp_ma || rsp_ta))
            begin
              st_set[ip][ip_pri ? (rsp_ma ? ST_RMA : ST_RTA) : (rsp_ma ? SS_RMA : SS_RTA)] = 1'b1;
              st_set[ip][ip_pri ? SS_STA : ST_STA] = 1'b1;
              st_set[eg][is_pri(eg) ? SS_RTA : ST_RTA] = 1'b1;
              st_set[eg][is_pri(eg) ? ST_STA : SS_STA] = 1'b1;
              err_o = 1'b1;
              nxa_o = 1'b0;
            end
          end
        end
      endcase
    end
    alloc = (act == A_FORWARD) &&
            (pkt_kind == K_NONPOSTED || pkt_kind == K_CFG1 || pkt_kind == K_FLUSH);
    if (alloc)
    begin
      tag_o = free_idx;
      uid_o = uid_q[eg];
    end
  end

  assign pkt_ready = !(alloc && !free_any);
  wire logic acc = pkt_valid && pkt_ready;

  // Table bookkeeping
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tv_q <= '{default: 1'b0};
    else if (acc && alloc)
      tv_q[free_idx] <= 1'b1;
    else if (acc && rel)
      tv_q[source_tag] <= 1'b0;
  end

  always_ff @(posedge pclk)
  begin
    if (acc && alloc)
    begin
      ttag_q[free_idx] <= source_tag;
      tseq_q[free_idx] <= sequence_id;
      tuid_q[free_idx] <= unit_id_a;
      tprt_q[free_idx] <= ip;
    end
  end

  // Registered decision; payload copied untouched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid       <= 1'b0;
      out_action      <= A_DROP;
      out_port        <= '0;
      out_compat      <= 1'b0;
      out_err         <= 1'b0;
      out_nxa         <= 1'b0;
      out_source_tag  <= '0;
      out_sequence_id <= '0;
      out_unit_id     <= '0;
      out_event_mask  <= '0;
      out_data        <= '0;
    end
    else
    begin
      out_valid <= acc;
      if (acc)
      begin
        out_action      <= act;
        out_port        <= eg;
        out_compat      <= compat_o;
        out_err         <= err_o;
        out_nxa         <= nxa_o;
        out_source_tag  <= tag_o;
        out_sequence_id <= seq_o;
        out_unit_id     <= uid_o;
        out_event_mask  <= evm;
        out_data        <= pkt_data;
      end
    end
  end

  // Per-port registers
  for (genvar i = 0; i < MAXP; i++)
  begin : g_port
    localparam logic [PW-1:0] DP_RST = (i < NPRI) ? PW'(NPRI) : PW'(0);
    localparam logic          PRI    = (i < NPRI);
    wire logic wr_ctrl = wr_en && (int'(a_port) == i) && (a_word == REG_CTRL) && (i < NPORT);
    wire logic wr_bus  = wr_en && (int'(a_port) == i) && (a_word == REG_BUS) && (i < NPORT);
    wire logic wr_stat = wr_en && (int'(a_port) == i) && (a_word == REG_STAT) && (i < NPORT);
    wire logic [NSTAT-1:0] clr = wr_stat ? pwdata[NSTAT-1:0] : '0;
    wire logic [NSTAT-1:0] set = acc ? st_set[i] : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        dec_q[i] <= RST_DEC;
        mam_q[i] <= 1'b0;
        uce_q[i] <= 1'b0;
        slv_q[i] <= 1'b0;
        dp_q[i]  <= DP_RST;
        dn_q[i]  <= RST_DEVNUM;
        pm_q[i]  <= RST_MASK;
        pb_q[i]  <= RST_BUS;
        sb_q[i]  <= RST_BUS;
        ub_q[i]  <= RST_BUS;
        uid_q[i] <= RST_UID;
        st_q[i]  <= '0;
      end
      else
      begin
        if (wr_ctrl)
        begin
          dec_q[i] <= pwdata[CTRL_DEC];
          mam_q[i] <= pwdata[CTRL_MAM];
          uce_q[i] <= pwdata[CTRL_UCE];
          slv_q[i] <= PRI & pwdata[CTRL_SLV];
          dp_q[i]  <= pwdata[CTRL_DP_LSB +: PW];
          dn_q[i]  <= pwdata[CTRL_DN_LSB +: DNW];
          pm_q[i]  <= pwdata[CTRL_PM_LSB +: MAXP];
        end
        if (wr_bus)
        begin
          pb_q[i]  <= pwdata[BUS_PRI_LSB +: BW];
          sb_q[i]  <= pwdata[BUS_SEC_LSB +: BW];
          ub_q[i]  <= pwdata[BUS_SUB_LSB +: BW];
          uid_q[i] <= pwdata[BUS_UID_LSB +: UW];
        end
        st_q[i] <= (st_q[i] & ~clr) | set;
      end
    end
  end

endmodule : lsr_router

`default_nettype wire

//--- lsr_pkg.sv
// Constants, field layout and types of the link switch router
package lsr_pkg;

  localparam int PW   = 4;
  localparam int MAXP = 16;
  localparam int TW   = 5;
  localparam int SQW  = 4;
  localparam int UW   = 5;
  localparam int BW   = 8;
  localparam int DNW  = 5;
  localparam int DW   = 32;
  localparam int AW   = 12;

  // Register word offsets inside one port's 16-byte window
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_BUS  = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;

  // Control register fields
  localparam int CTRL_DEC    = 0;
  localparam int CTRL_MAM    = 1;
  localparam int CTRL_UCE    = 2;
  localparam int CTRL_SLV    = 3;
  localparam int CTRL_DP_LSB = 4;
  localparam int CTRL_DN_LSB = 8;
  localparam int CTRL_PM_LSB = 16;

  // Bus register fields
  localparam int BUS_PRI_LSB = 0;
  localparam int BUS_SEC_LSB = 8;
  localparam int BUS_SUB_LSB = 16;
  localparam int BUS_UID_LSB = 24;

  // Status register bits, write one to clear
  localparam int ST_EOC  = 0;
  localparam int ST_HEOC = 1;
  localparam int ST_RSPE = 2;
  localparam int ST_RMA  = 3;
  localparam int ST_RTA  = 4;
  localparam int ST_STA  = 5;
  localparam int SS_RMA  = 6;
  localparam int SS_RTA  = 7;
  localparam int SS_STA  = 8;
  localparam int NSTAT   = 9;

  // Reset values
  localparam logic             RST_DEC    = 1'b0;
  localparam logic [MAXP-1:0]  RST_MASK   = 16'hFFFF;
  localparam logic [DNW-1:0]   RST_DEVNUM = 5'h00;
  localparam logic [BW-1:0]    RST_BUS    = 8'h00;
  localparam logic [UW-1:0]    RST_UID    = 5'h00;

  typedef enum logic [2:0] {
    K_POSTED    = 3'b000,
    K_NONPOSTED = 3'b001,
    K_CFG0      = 3'b010,
    K_CFG1      = 3'b011,
    K_FLUSH     = 3'b100,
    K_FENCE     = 3'b101,
    K_RESP      = 3'b110,
    K_EVENT     = 3'b111
  } lsr_kind_e;

  typedef enum logic [2:0] {
    A_DROP    = 3'b000,
    A_FORWARD = 3'b001,
    A_LOCAL   = 3'b010,
    A_MABORT  = 3'b011,
    A_EVENT   = 3'b100
  } lsr_action_e;

endpackage : lsr_pkg

//--- lsr_router_asserts.sv
// Concurrent checks on the ports of the link switch router
`timescale 1ns/10ps
`default_nettype none
module lsr_router_asserts
  import lsr_pkg::*;
#(
  parameter int NPORT = 8,
  parameter int NPRI  = 2
)(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic [AW-1:0]   paddr,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            pkt_valid,
  input wire logic            pkt_ready,
  input wire logic [PW-1:0]   pkt_port,
  input wire lsr_kind_e       pkt_kind,
  input wire logic            pkt_bridge,
  input wire logic [DW-1:0]   pkt_data,
  input wire logic            out_valid,
  input wire lsr_action_e     out_action,
  input wire logic [PW-1:0]   out_port,
  input wire logic            out_compat,
  input wire logic [MAXP-1:0] out_event_mask,
  input wire logic [DW-1:0]   out_data
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_take;
    pkt_valid && pkt_ready;
  endsequence
  sequence s_up_take;
    s_take ##0 (pkt_port >= NPRI);
  endsequence
  sequence s_dn_take;
    s_take ##0 (pkt_port < NPRI);
  endsequence
  chk_out_pulse: assert property (!(pkt_valid && pkt_ready) |=> !out_valid)
    else $error("decision without accepted packet");
  chk_data_passes: assert property (s_take |=> out_valid && out_data == $past(pkt_data))
    else $error("payload word altered or late");
  chk_fence_drop: assert property (s_dn_take ##0 (pkt_kind == K_FENCE) |=> out_action == A_DROP)
    else $error("downstream fence not dropped");
  chk_flush_abort: assert property (s_dn_take ##0 (pkt_kind == K_FLUSH) |=> out_action == A_MABORT)
    else $error("downstream flush not aborted");
  chk_up_bridge: assert property (s_up_take ##0 (pkt_kind == K_RESP && pkt_bridge) |=> out_action == A_DROP)
    else $error("upstream bridged response kept");
  chk_dn_bridge: assert property (s_dn_take ##0 (pkt_kind == K_RESP && !pkt_bridge) |=> out_action == A_DROP)
    else $error("downstream unbridged response kept");
  chk_event_ingress: assert property (s_take ##0 (pkt_kind == K_EVENT) |=>
    out_action == A_EVENT && !out_event_mask[$past(pkt_port)])
    else $error("event sent back to ingress");
  chk_peer_compat: assert property (s_up_take ##1 (out_action == A_FORWARD && out_port >= NPRI &&
    out_port != $past(pkt_port)) |-> !out_compat)
    else $error("legacy flag kept on peer forward");
  chk_ready_kind: assert property (!pkt_ready |-> pkt_kind inside {K_NONPOSTED, K_CFG1, K_FLUSH})
    else $error("packet refused without need of a tag");
  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("wait state on register bus");
  chk_unmapped_err: assert property (psel && penable && paddr[11:8] != 4'h0 |-> pslverr)
    else $error("unmapped access without error");
endmodule : lsr_router_asserts
bind lsr_router lsr_router_asserts #(.NPORT(NPORT), .NPRI(NPRI)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_port(pkt_port), .pkt_kind(pkt_kind),
  .pkt_bridge(pkt_bridge), .pkt_data(pkt_data), .out_valid(out_valid), .out_action(out_action),
  .out_port(out_port), .out_compat(out_compat), .out_event_mask(out_event_mask), .out_data(out_data));
`default_nettype wire

//--- lsr_chain_model.sv
// Far-side chain model: answers with the source tag of the last forwarded decision, request or not
`timescale 1ns/10ps
`default_nettype none
module lsr_chain_model
  import lsr_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          out_valid,
  input  wire lsr_action_e   out_action,
  input  wire logic [TW-1:0] out_source_tag,
  output logic      [TW-1:0] ret_tag
);
  // The far chain returns the reassigned tag so the switch can find its entry
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ret_tag <= '0;
    else if (out_valid && out_action == A_FORWARD)
      ret_tag <= out_source_tag;
  end
endmodule : lsr_chain_model
`default_nettype wire

//--- link_switch_router_test.sv
// Self-checking bench of the link switch router
`timescale 1ns/10ps
`default_nettype none
module link_switch_router_test;
  import lsr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [DW-1:0] pwdata = '0, prdata, pkt_data = '0, out_data, rd, v, q;
  logic pready, pslverr, pkt_valid = 1'b0, pkt_ready, pkt_compat = 1'b0, pkt_bridge = 1'b0;
  logic pkt_err = 1'b0, pkt_nxa = 1'b0, out_valid, out_compat, out_err, out_nxa, slv;
  logic [PW-1:0] pkt_port = '0, pkt_dest = '0, out_port;
  lsr_kind_e pkt_kind = K_POSTED;
  lsr_action_e out_action;
  logic [TW-1:0] source_tag = '0, out_source_tag, ret_tag, tg, rt;
  logic [SQW-1:0] sequence_id = '0, out_sequence_id;
  logic [UW-1:0] unit_id_a = '0, out_unit_id;
  logic [BW-1:0] pkt_bus = '0;
  logic [DNW-1:0] pkt_dev = '0;
  logic [MAXP-1:0] out_event_mask;
  logic [15:0] lf = 16'h004E;
  int err_total = 0, tests_run = 0;
  always #2.5 pclk = ~pclk;
  lsr_router #(.NPORT(8), .NPRI(2), .TAGS(32)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_port(pkt_port), .pkt_kind(pkt_kind),
    .pkt_dest(pkt_dest), .pkt_compat(pkt_compat), .pkt_bridge(pkt_bridge), .pkt_err(pkt_err), .pkt_nxa(pkt_nxa),
    .source_tag(source_tag), .sequence_id(sequence_id), .unit_id_a(unit_id_a), .pkt_bus(pkt_bus),
    .pkt_dev(pkt_dev), .pkt_data(pkt_data), .out_valid(out_valid), .out_action(out_action), .out_port(out_port),
    .out_compat(out_compat), .out_err(out_err), .out_nxa(out_nxa), .out_source_tag(out_source_tag),
    .out_sequence_id(out_sequence_id), .out_unit_id(out_unit_id), .out_event_mask(out_event_mask),
    .out_data(out_data));
  lsr_chain_model far (.pclk(pclk), .presetn(presetn), .out_valid(out_valid), .out_action(out_action),
    .out_source_tag(out_source_tag), .ret_tag(ret_tag));
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    v[15:0] = lf;
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    v[31:16] = lf;
  endtask : rnd
  function automatic logic [AW-1:0] ra(input logic [3:0] p, input logic [3:0] o);
    return {4'h0, p, o};
  endfunction : ra
  // Flags expected on the response's ingress and egress ports per abort case
  function automatic logic [DW-1:0] ing_flags(input int j);
    return j == 0 ? (32'h1 << SS_RTA) | (32'h1 << ST_STA) :
           j == 1 ? (32'h1 << SS_RMA) : (32'h1 << SS_RMA) | (32'h1 << ST_STA);
  endfunction : ing_flags
  function automatic logic [DW-1:0] egr_flags(input int j);
    return j == 1 ? 32'h0 : (32'h1 << SS_RTA) | (32'h1 << ST_STA);
  endfunction : egr_flags
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      err_total++;
      wrap_up();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic stat(input logic [3:0] p, input logic [DW-1:0] e);
    apb(1'b0, ra(p, REG_STAT), 32'h0);
    chk(rd[NSTAT-1:0] === e[NSTAT-1:0], "status flags");
    apb(1'b1, ra(p, REG_STAT), 32'h000001FF);
  endtask : stat
  task automatic send(input logic [3:0] p, input lsr_kind_e k, input logic [3:0] d, input logic c,
                      input logic b, input logic e, input logic n, input logic [TW-1:0] t);
    int i;
    rnd();
    @(posedge pclk);
    pkt_valid <= 1'b1;
    pkt_port <= p;
    pkt_kind <= k;
    pkt_dest <= d;
    pkt_compat <= c;
    pkt_bridge <= b;
    pkt_err <= e;
    pkt_nxa <= n;
    source_tag <= t;
    sequence_id <= v[3:0];
    unit_id_a <= v[8:4];
    pkt_data <= v;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pkt_ready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      err_total++;
      wrap_up();
    end
    pkt_valid <= 1'b0;
    #1;
    chk(out_valid === 1'b1 && out_data === v, "decision word");
  endtask : send
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ra(0, REG_CTRL), 32'h0);
    chk(rd === 32'hFFFF0020, "primary control at reset");
    apb(1'b1, ra(2, REG_CTRL), 32'hFFFF0008);
    apb(1'b0, ra(2, REG_CTRL), 32'h0);
    chk(rd === 32'hFFFF0000, "secondary slave bit");
    apb(1'b0, 12'h100, 32'h0);
    chk(slv === 1'b1 && rd === 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++)
    begin
      rnd();
      send(4'h0, K_POSTED, v[3:0], v[4], 1'b0, 1'b0, 1'b0, 5'h00);
      chk(out_action === A_FORWARD && out_port === 4'h2, "default route");
    end
    apb(1'b1, ra(0, REG_CTRL), 32'hFFFF0031);
    send(4'h0, K_POSTED, 4'h5, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_FORWARD && out_port === 4'h3, "legacy route");
    apb(1'b1, ra(0, REG_CTRL), 32'hFFF70031);
    send(4'h0, K_POSTED, 4'h5, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_DROP, "legacy port outside mask");
    apb(1'b1, ra(0, REG_CTRL), 32'hFFFF0020);
    send(4'h2, K_POSTED, 4'h4, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_FORWARD && out_port === 4'h4 && out_compat === 1'b0, "peer legacy flag");
    send(4'h0, K_FENCE, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_DROP, "downstream fence");
    stat(4'h0, 32'h1 << ST_EOC);
    send(4'h0, K_FLUSH, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_MABORT, "downstream flush");
    send(4'h2, K_FLUSH, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_FORWARD && out_port === 4'h0, "upstream flush");
    send(4'h0, K_CFG0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_LOCAL && out_port === 4'h0, "type 0 own header");
    send(4'h3, K_CFG0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_LOCAL && out_port === 4'h3, "type 0 device field");
    send(4'h3, K_CFG1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action !== A_FORWARD, "upstream config gated");
    apb(1'b1, ra(3, REG_BUS), 32'h00070500);
    pkt_bus <= 8'h06;
    send(4'h0, K_CFG1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_FORWARD && out_port === 4'h3, "type 1 bus range");
    pkt_bus <= 8'h00;
    pkt_dev <= 5'h03;
    send(4'h0, K_CFG1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_LOCAL && out_port === 4'h3, "type 1 header on internal bus");
    send(4'h0, K_EVENT, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_EVENT && out_event_mask === 16'h00FE, "event spread");
    stat(4'h2, 32'h0);
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b1, ra(2, REG_CTRL), j == 2 ? 32'hFFFF0002 : 32'hFFFF0000);
      rnd();
      tg = v[TW-1:0];
      send(4'h0, K_NONPOSTED, 4'h6, 1'b0, 1'b0, 1'b0, 1'b0, tg);
      q = v;
      chk(out_action === A_FORWARD && out_port === 4'h2, "request out");
      @(posedge pclk);
      #1;
      rt = ret_tag;
      send(4'h2, K_RESP, 4'h0, 1'b0, 1'b0, 1'b1, j != 0, rt);
      chk(out_action === A_FORWARD && out_port === 4'h0 && out_source_tag === tg, "response back");
      chk(out_sequence_id === q[3:0] && out_unit_id === q[8:4], "original fields back");
      chk(out_err === (j != 1) && (j == 1 || out_nxa === 1'b0), "abort conversion");
      stat(4'h2, ing_flags(j));
      stat(4'h0, egr_flags(j));
      send(4'h2, K_RESP, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, rt);
      chk(out_action === A_DROP, "entry released");
      stat(4'h2, 32'h1 << ST_RSPE);
    end
    send(4'h2, K_RESP, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_DROP, "upstream bridged response");
    stat(4'h2, 32'h1 << ST_HEOC);
    send(4'h0, K_RESP, 4'h2, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    chk(out_action === A_DROP, "downstream unbridged response");
    stat(4'h0, 32'h1 << ST_EOC);
    wrap_up();
  end
endmodule : link_switch_router_test
`default_nettype wire
